//--- logic/pms_adc_seq.sv
// Converter sequencer with register file, Avalon slave and serial slave
`timescale 1ns/10ps
`include "pms_map.svh"
module pms_adc_seq #(
  parameter int SCAN_CYC = `PMS_SCAN_CYC,
  parameter int SNAP_SENSE_CYC = `PMS_SNAP_SENSE_CYC,
  parameter int SNAP_OTHER_CYC = `PMS_SNAP_OTHER_CYC,
  parameter bit INVERT_OUT = 1'b1,
  parameter logic [1:0] CODE_SENSE = 2'h0,
  parameter logic [1:0] CODE_SUPPLY = 2'h1,
  parameter logic [1:0] CODE_AUX = 2'h2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Avalon-MM slave
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Converter front end
  input wire logic [11:0] adc_result,
  output logic adc_run,
  output logic [1:0] adc_chan,
  output logic shutdown_active,
  // Pins: shutdown and three-state address selects (00 low, 01 open, 10 high)
  input wire logic shutdown_in_n,
  input wire logic [1:0] addr_select_lo,
  input wire logic [1:0] addr_select_hi,
  // Serial bus pins
  input wire logic scl_in,
  input wire logic split_data_in,
  output logic split_data_out,
  output logic split_data_out_oe
);
  // Pin synchronisers, third stage only for edge finding
  logic scl_s1, scl_s2, scl_s3, sda_s1, sda_s2, sda_s3, shd_s1, shd_s2;
  logic [1:0] asl_s1, asl_s2, ash_s1, ash_s2;
  // Register file
  logic [7:0] data_reg [0:5];
  logic [7:0] ctrl_reg;
  logic [7:0] rd_view [0:7];
  // Avalon handshake
  logic wait_reg;
  logic [31:0] rdata_reg;
  // Converter sequencer
  pms_pkg::pms_conv_st_t cst_reg, cst_next;
  logic [`PMS_CNT_W-1:0] cnt_reg, cnt_next;
  logic [1:0] ch_reg, ch_next;
  logic busy_reg, busy_next, run_reg, run_next;
  // Serial slave
  pms_pkg::pms_ser_st_t ist_reg, ist_next;
  logic [3:0] bit_reg, bit_next;
  logic [7:0] sh_reg, sh_next, tx_reg, tx_next;
  logic [2:0] ptr_reg, ptr_next, widx_reg, widx_next;
  logic [7:0] wdat_reg, wdat_next;
  logic ack_reg, ack_next, iwr_reg, iwr_next, out_reg, out_next, oe_reg;

  // Synchronise the serial, shutdown and select pins through two flops
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      {scl_s1, scl_s2, scl_s3, sda_s1, sda_s2, sda_s3} <= 6'h3F;
      {shd_s1, shd_s2} <= 2'h3;
      {asl_s1, asl_s2, ash_s1, ash_s2} <= 8'h00;
    end else begin
      {scl_s1, scl_s2, scl_s3} <= {scl_in, scl_s1, scl_s2};
      {sda_s1, sda_s2, sda_s3} <= {split_data_in, sda_s1, sda_s2};
      {shd_s1, shd_s2} <= {shutdown_in_n, shd_s1};
      {asl_s1, asl_s2, ash_s1, ash_s2} <= {addr_select_lo, asl_s1, addr_select_hi, ash_s1};
    end
  end

  // Bus events seen on the synchronised pins
  wire scl_rise = scl_s2 & ~scl_s3;
  wire scl_fall = ~scl_s2 & scl_s3;
  wire bus_start = scl_s2 & scl_s3 & sda_s3 & ~sda_s2;
  wire bus_stop = scl_s2 & scl_s3 & ~sda_s3 & sda_s2;
  // Nine addresses: 110 then index hi*3+lo of the three-state levels
  wire [3:0] sel_idx = 4'(ash_s2 * 2'd3) + {2'h0, asl_s2};
  wire [6:0] own_addr = {`PMS_ADDR_BASE, sel_idx};

  // Avalon decode; a write lands on the edge where waitrequest is seen low
  wire av_word_ok = (avs_address[1:0] == 2'h0);
  wire [2:0] av_idx = avs_address[4:2];
  wire av_wr_fire = avs_write & ~wait_reg & av_word_ok;
  // Common write port; the Avalon side wins a same-cycle clash
  wire wr_en = av_wr_fire | iwr_reg;
  wire [2:0] wr_idx = av_wr_fire ? av_idx : widx_reg;
  wire [7:0] wr_data = av_wr_fire ? avs_writedata[7:0] : wdat_reg;
  wire ctrl_wr = wr_en & (wr_idx == `PMS_IDX_CTRL);
  wire freeze = ctrl_reg[`PMS_CTL_FREEZE];
  // Only a clear-to-set edge of the snapshot bit starts a conversion
  wire snap_trig = ctrl_wr & wr_data[`PMS_CTL_SNAP] & ~ctrl_reg[`PMS_CTL_SNAP];
  wire [1:0] sel_code = wr_data[`PMS_CTL_CHS_HI:`PMS_CTL_CHS_LO];
  // Code-to-channel map; an unmapped code starts nothing
  wire code_ok = (sel_code == CODE_SENSE) | (sel_code == CODE_SUPPLY) | (sel_code == CODE_AUX);
  wire [1:0] code_ch = (sel_code == CODE_SENSE) ? 2'h0 : (sel_code == CODE_SUPPLY) ? 2'h1 : 2'h2;
  wire conv_done = run_reg & (cnt_reg == '0);
  wire store_en = conv_done & ~freeze;
  wire shd_low = ~shd_s2;

  // Register file entries; converter stores yield to the freeze bit
  genvar gi;
  generate
    for (gi = 0; gi < `PMS_DATA_REGS; gi++) begin : g_data
      wire hit_cv = store_en & (ch_reg == 2'(gi / 2));
      // Straight binary code: value divided by the channel step
      wire [7:0] cv_byte = (gi % 2 == 0) ? adc_result[11:4] : {adc_result[3:0], 4'h0};
      wire hit_wr = wr_en & freeze & (wr_idx == 3'(gi));
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          data_reg[gi] <= `PMS_DATA_RESET;
        end else if (hit_wr) begin
          data_reg[gi] <= wr_data;
        end else if (hit_cv) begin
          data_reg[gi] <= cv_byte;
        end
      end
      // Busy overlays the low-order register of the converting channel
      wire busy_here = busy_reg & (gi % 2 == 1) & (ch_reg == 2'(gi / 2));
      assign rd_view[gi] = data_reg[gi] | (busy_here ? `PMS_BUSY_MASK : 8'h00);
    end
  endgenerate
  assign rd_view[6] = ctrl_reg;
  assign rd_view[7] = {busy_reg, run_reg, ch_reg, cst_reg};

  // Control register and Avalon answer, one wait cycle per access
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_reg <= `PMS_CTL_RESET;
      wait_reg <= 1'b1;
      rdata_reg <= '0;
    end else begin
      if (ctrl_wr) begin
        ctrl_reg <= wr_data;
      end
      wait_reg <= ~((avs_read | avs_write) & wait_reg);
      rdata_reg <= {24'h0, av_word_ok ? rd_view[av_idx] : 8'h00};
    end
  end

  // Converter sequencing: scan, snapshot, halt after snapshot, shutdown
  always_comb begin
    cst_next = cst_reg;
    cnt_next = (run_reg && cnt_reg != '0) ? cnt_reg - 1'b1 : cnt_reg;
    ch_next = ch_reg;
    busy_next = busy_reg;
    run_next = run_reg;
    case (cst_reg)
      pms_pkg::PMS_CV_SCAN: begin
        // Sense, supply, auxiliary, round again
        if (conv_done) begin
          ch_next = (ch_reg == 2'h2) ? 2'h0 : ch_reg + 2'h1;
          cnt_next = `PMS_CNT_W'(SCAN_CYC - 1);
        end
        busy_next = 1'b0;
      end
      pms_pkg::PMS_CV_SNAP: begin
        if (conv_done) begin
          busy_next = 1'b0;
          run_next = 1'b0;
          cst_next = pms_pkg::PMS_CV_HALT;
        end
      end
      pms_pkg::PMS_CV_HALT: begin
        // Result stays put until software leaves snapshot mode
        if (!ctrl_reg[`PMS_CTL_SNAP]) begin
          cst_next = pms_pkg::PMS_CV_SCAN;
          ch_next = 2'h0;
          cnt_next = `PMS_CNT_W'(SCAN_CYC - 1);
          run_next = 1'b1;
        end
      end
      pms_pkg::PMS_CV_SHUTDOWN_IN_N: begin
        // Restart the scan from the sense channel on wake
        if (!shd_low) begin
          cst_next = pms_pkg::PMS_CV_SCAN;
          ch_next = 2'h0;
          cnt_next = `PMS_CNT_W'(SCAN_CYC - 1);
          run_next = 1'b1;
        end
      end
      default: begin
        cst_next = pms_pkg::PMS_CV_SCAN;
        run_next = 1'b1;
      end
    endcase
    if (snap_trig && code_ok && cst_reg != pms_pkg::PMS_CV_SHUTDOWN_IN_N) begin
      cst_next = pms_pkg::PMS_CV_SNAP;
      ch_next = code_ch;
      cnt_next = (code_ch == 2'h0) ? `PMS_CNT_W'(SNAP_SENSE_CYC - 1) : `PMS_CNT_W'(SNAP_OTHER_CYC - 1);
      busy_next = 1'b1;
      run_next = 1'b1;
    end
    if (shd_low) begin
      cst_next = pms_pkg::PMS_CV_SHUTDOWN_IN_N;
      busy_next = 1'b0;
      run_next = 1'b0;
    end
  end

  // Converter state flops; scan is the power-up default
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cst_reg <= pms_pkg::PMS_CV_SCAN;
      cnt_reg <= `PMS_CNT_W'(SCAN_CYC - 1);
      ch_reg <= 2'h0;
      {busy_reg, run_reg} <= 2'h1;
    end else begin
      cst_reg <= cst_next;
      cnt_reg <= cnt_next;
      ch_reg <= ch_next;
      {busy_reg, run_reg} <= {busy_next, run_next};
    end
  end

  // Serial slave; bits taken on rising clock, output changed on falling
  wire [7:0] byte_in = {sh_reg[6:0], sda_s2};
  wire [2:0] ptr_inc = (ptr_reg == `PMS_PTR_LAST) ? 3'h0 : ptr_reg + 3'h1;
  wire addr_hit = (byte_in[7:1] == own_addr) | ((byte_in[7:1] == `PMS_ADDR_MASS) & ~byte_in[0]);
  always_comb begin
    ist_next = ist_reg;
    bit_next = bit_reg;
    sh_next = sh_reg;
    tx_next = tx_reg;
    ptr_next = ptr_reg;
    ack_next = ack_reg;
    iwr_next = 1'b0;
    widx_next = widx_reg;
    wdat_next = wdat_reg;
    out_next = out_reg;
    if (bus_start) begin
      ist_next = pms_pkg::PMS_IC_ADDR;
      bit_next = 4'h0;
      ack_next = 1'b0;
    end else if (bus_stop) begin
      ist_next = pms_pkg::PMS_IC_IDLE;
      ptr_next = 3'h0;
      ack_next = 1'b0;
      out_next = 1'b1;
    end else if (scl_rise && ist_reg != pms_pkg::PMS_IC_IDLE) begin
      if (bit_reg == 4'h8) begin
        // Ninth clock: our acknowledge ends, or the master's is read
        bit_next = 4'h0;
        ack_next = 1'b0;
        if (ist_reg == pms_pkg::PMS_IC_RDAT) begin
          // Our own address acknowledge or the master's fetches a byte; a master refusal ends the read
          if (sda_s2 && !ack_reg) begin
            ist_next = pms_pkg::PMS_IC_IDLE;
          end else begin
            tx_next = rd_view[ptr_reg];
            ptr_next = ptr_inc;
          end
        end
      end else begin
        sh_next = byte_in;
        bit_next = bit_reg + 4'h1;
        if (bit_reg == 4'h7) begin
          case (ist_reg)
            pms_pkg::PMS_IC_ADDR: begin
              ack_next = addr_hit;
              // First read byte is fetched on the acknowledge clock, not here, so the pointer moves once
              ist_next = !addr_hit ? pms_pkg::PMS_IC_IDLE : byte_in[0] ? pms_pkg::PMS_IC_RDAT : pms_pkg::PMS_IC_CMD;
            end
            pms_pkg::PMS_IC_CMD: begin
              ptr_next = byte_in[2:0];
              ack_next = 1'b1;
              ist_next = pms_pkg::PMS_IC_WDAT;
            end
            pms_pkg::PMS_IC_WDAT: begin
              iwr_next = 1'b1;
              widx_next = ptr_reg;
              wdat_next = byte_in;
              ptr_next = ptr_inc;
              ack_next = 1'b1;
            end
            default: begin
              ack_next = 1'b0;
            end
          endcase
        end
      end
    end else if (scl_fall) begin
      // Acknowledge low, read bit MSB first, else released
      if (bit_reg == 4'h8) begin
        out_next = ~ack_reg;
      end else if (ist_reg == pms_pkg::PMS_IC_RDAT) begin
        out_next = tx_reg[~bit_reg[2:0]];
      end else begin
        out_next = 1'b1;
      end
    end
  end

  // Serial state flops; the pin pull follows the variant's polarity
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ist_reg <= pms_pkg::PMS_IC_IDLE;
      {bit_reg, sh_reg, tx_reg} <= 20'h00000;
      {ptr_reg, widx_reg, wdat_reg} <= 14'h0000;
      {ack_reg, iwr_reg, out_reg} <= 3'h1;
      oe_reg <= INVERT_OUT;
    end else begin
      ist_reg <= ist_next;
      {bit_reg, sh_reg, tx_reg} <= {bit_next, sh_next, tx_next};
      {ptr_reg, widx_reg, wdat_reg} <= {ptr_next, widx_next, wdat_next};
      {ack_reg, iwr_reg, out_reg} <= {ack_next, iwr_next, out_next};
      oe_reg <= INVERT_OUT ? out_next : ~out_next;
    end
  end

  // Outputs straight from flops; the split data output is tied low
  assign avs_waitrequest = wait_reg;
  assign avs_readdata = rdata_reg;
  assign adc_run = run_reg;
  assign adc_chan = ch_reg;
  assign shutdown_active = cst_reg[3];
  assign split_data_out = 1'b0;
  assign split_data_out_oe = oe_reg;

  // Checks on the sequencer and the serial output
  property p_scan_order;
    @(posedge clk) disable iff (!reset_n)
    (cst_reg == pms_pkg::PMS_CV_SCAN && conv_done && ch_reg == 2'h0 && !snap_trig && shd_s2) |=> (ch_reg == 2'h1);
  endproperty
  a_scan_order: assert property (p_scan_order) else $error("scan order broken");
  property p_split;
    @(posedge clk) disable iff (!reset_n)
    (store_en && ch_reg == 2'h1 && !wr_en) |=> (data_reg[2] == $past(adc_result[11:4]) && data_reg[3][3:0] == 4'h0);
  endproperty
  a_split: assert property (p_split) else $error("result split wrong");
  property p_scan_reload;
    @(posedge clk) disable iff (!reset_n)
    (cst_reg == pms_pkg::PMS_CV_SCAN && conv_done && !snap_trig && shd_s2) |=> (cnt_reg == `PMS_CNT_W'(SCAN_CYC - 1));
  endproperty
  a_scan_reload: assert property (p_scan_reload) else $error("scan period wrong");
  property p_freeze;
    @(posedge clk) disable iff (!reset_n)
    (freeze && !wr_en) |=> $stable(data_reg[0]) && $stable(data_reg[5]);
  endproperty
  a_freeze: assert property (p_freeze) else $error("frozen data changed");
  property p_snap_start;
    @(posedge clk) disable iff (!reset_n)
    (snap_trig && code_ok && shd_s2 && cst_reg != pms_pkg::PMS_CV_SHUTDOWN_IN_N) |=> busy_reg && run_reg ##1 busy_reg;
  endproperty
  a_snap_start: assert property (p_snap_start) else $error("snapshot did not start");
  property p_snap_end;
    @(posedge clk) disable iff (!reset_n)
    (cst_reg == pms_pkg::PMS_CV_SNAP && conv_done && !snap_trig && shd_s2) |=> (!busy_reg && !run_reg);
  endproperty
  a_snap_end: assert property (p_snap_end) else $error("snapshot did not end");
  property p_scan_idle;
    @(posedge clk) disable iff (!reset_n)
    (cst_reg == pms_pkg::PMS_CV_SCAN) |-> !busy_reg;
  endproperty
  a_scan_idle: assert property (p_scan_idle) else $error("busy set in scan");
  property p_shutdown;
    @(posedge clk) disable iff (!reset_n)
    $fell(shd_s2) |=> (shutdown_active && !adc_run);
  endproperty
  a_shutdown: assert property (p_shutdown) else $error("shutdown not entered");
  property p_ack;
    @(posedge clk) disable iff (!reset_n)
    (scl_fall && bit_reg == 4'h8 && ack_reg && !bus_start && !bus_stop) |=> (split_data_out_oe == !INVERT_OUT);
  endproperty
  a_ack: assert property (p_ack) else $error("acknowledge not driven");
  c_snapshot: cover property (@(posedge clk) disable iff (!reset_n) busy_reg ##1 !busy_reg);
  c_wrap: cover property (@(posedge clk) disable iff (!reset_n) conv_done && ch_reg == 2'h2);
  c_i2c_write: cover property (@(posedge clk) disable iff (!reset_n) iwr_reg);
  c_shutdown_in_n: cover property (@(posedge clk) disable iff (!reset_n) cst_reg == pms_pkg::PMS_CV_SHUTDOWN_IN_N);
endmodule : pms_adc_seq

//--- logic/pms_map.svh
// Register map, field positions, reset values and timing counts of the monitor sequencer
// Behaviour
// - Power-up scan order: sense, supply, auxiliary
// - Result split: upper eight, lower four bits
// - Scan refreshes all six registers at 7.5Hz
// - Freeze bit stops updates, allows free access
// - Snapshot write starts conversion, sets busy
// - Snapshot end halts converter, clears busy
// - Snapshot result kept in channel register pair
// - Busy flag stays clear during scan
// - Sense code: 20uV step, 81.92mV full scale
// - Supply code: 25mV step, 102.4V full scale
// - Auxiliary code: 0.5mV step, 2.048V full scale
// - Low shutdown input enters shutdown; open is inactive
// - Two three-state selects give nine addresses
// - Serial data shifted on rising bus clock
// - Inverted variant drives complement on data output
// - Split data output returns data and acknowledges
`ifndef PMS_MAP_SVH
`define PMS_MAP_SVH
// Register indices; byte address is four times the index
`define PMS_IDX_CTRL 3'h6
`define PMS_IDX_STATUS 3'h7
`define PMS_PTR_LAST 3'h6
`define PMS_DATA_REGS 6
// Control field positions
`define PMS_CTL_SNAP 7
`define PMS_CTL_CHS_HI 6
`define PMS_CTL_CHS_LO 5
`define PMS_CTL_FREEZE 4
`define PMS_CTL_RESET 8'h0C
`define PMS_DATA_RESET 8'h00
// Busy flag position in a low-order data register
`define PMS_BUSY_MASK 8'h08
// Converter code weights, nanovolts per step and microvolts full scale
`define PMS_SENSE_STEP_NV 20000
`define PMS_SENSE_FS_UV 81920
`define PMS_SUPPLY_STEP_NV 25000000
`define PMS_SUPPLY_FS_UV 102400000
`define PMS_AUX_STEP_NV 500000
`define PMS_AUX_FS_UV 2048000
// Bus address pieces
`define PMS_ADDR_BASE 3'h6
`define PMS_ADDR_MASS 7'h66
// Timing
`define PMS_CLK_HZ 40000000
`define PMS_SCAN_RATE_DHZ 75
`define PMS_SCAN_CYC (`PMS_CLK_HZ * 10 / (`PMS_SCAN_RATE_DHZ * 3))
`define PMS_SNAP_SENSE_MS 67
`define PMS_SNAP_OTHER_MS 33
`define PMS_SNAP_SENSE_CYC (`PMS_SNAP_SENSE_MS * (`PMS_CLK_HZ / 1000))
`define PMS_SNAP_OTHER_CYC (`PMS_SNAP_OTHER_MS * (`PMS_CLK_HZ / 1000))
`define PMS_CNT_W 22
`endif

//--- logic/pms_pkg.sv
// Types shared by the monitor sequencer
package pms_pkg;
  // Converter sequencing states
  typedef enum logic [3:0] {
    PMS_CV_SCAN = 4'h1,
    PMS_CV_SNAP = 4'h2,
    PMS_CV_HALT = 4'h4,
    PMS_CV_SHUTDOWN_IN_N = 4'h8
  } pms_conv_st_t;
  // Serial slave states
  typedef enum logic [4:0] {
    PMS_IC_IDLE = 5'h01,
    PMS_IC_ADDR = 5'h02,
    PMS_IC_CMD = 5'h04,
    PMS_IC_WDAT = 5'h08,
    PMS_IC_RDAT = 5'h10
  } pms_ser_st_t;
endpackage : pms_pkg

//--- verif/pms_adc_seq_test.sv
// Self-checking bench for the monitor sequencer
`timescale 1ns/10ps
module pms_adc_seq_test;
  // Shortened conversion counts
  localparam int SCAN = 40;
  localparam int SNAP_S = 60;
  localparam int SNAP_O = 30;
  // Design pins
  logic clk, reset_n, avs_read, avs_write, avs_waitrequest;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [11:0] adc_result;
  logic adc_run, shutdown_active, shutdown_in_n;
  logic [1:0] adc_chan, addr_select_lo, addr_select_hi;
  logic scl, sda_in, split_data_out, split_data_out_oe;
  // Bookkeeping
  int err_count = 0;
  int num_checks = 0;
  int cyc = 0;
  int t0, snap;
  logic [11:0] bias = 12'h000;
  logic [11:0] ev;
  logic [1:0] last;
  logic [31:0] rd;
  logic [7:0] b;
  logic nak, ok;

  pms_adc_seq #(.SCAN_CYC(SCAN), .SNAP_SENSE_CYC(SNAP_S), .SNAP_OTHER_CYC(SNAP_O)) uut (
    .clk(clk), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .adc_result(adc_result), .adc_run(adc_run),
    .adc_chan(adc_chan), .shutdown_active(shutdown_active), .shutdown_in_n(shutdown_in_n),
    .addr_select_lo(addr_select_lo), .addr_select_hi(addr_select_hi), .scl_in(scl),
    .split_data_in(sda_in), .split_data_out(split_data_out), .split_data_out_oe(split_data_out_oe));

  pms_i2c_master #(.INVERT(1'b1)) host (
    .scl(scl), .sda_in(sda_in), .sda_out(split_data_out), .sda_oe(split_data_out_oe));

  // Non-inverted variant sharing every input but the serial pins
  logic scl2, sda_in2, sdo2, sdo_oe2;
  pms_adc_seq #(.SCAN_CYC(SCAN), .SNAP_SENSE_CYC(SNAP_S), .SNAP_OTHER_CYC(SNAP_O),
    .INVERT_OUT(1'b0)) uut_plain (
    .clk(clk), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(),
    .avs_waitrequest(), .adc_result(adc_result), .adc_run(),
    .adc_chan(), .shutdown_active(), .shutdown_in_n(shutdown_in_n),
    .addr_select_lo(addr_select_lo), .addr_select_hi(addr_select_hi), .scl_in(scl2),
    .split_data_in(sda_in2), .split_data_out(sdo2), .split_data_out_oe(sdo_oe2));

  pms_i2c_master #(.INVERT(1'b0)) host_plain (
    .scl(scl2), .sda_in(sda_in2), .sda_out(sdo2), .sda_oe(sdo_oe2));

  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Result of channel c; bias marks snapshot results apart from scan ones
  function automatic logic [11:0] res(input logic [1:0] c);
    return 12'hA51 + 12'h123 * c + bias;
  endfunction : res

  // Cycle count and converter front end, a result per channel
  always @(posedge clk) begin
    cyc <= cyc + 1;
    adc_result <= res(adc_chan);
  end

  task automatic conclude();
    if (err_count == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : conclude

  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] got);
    num_checks++;
    if (got !== e) begin
      $display("ERROR %s expected %h got %h", what, e, got);
      err_count++;
    end
  endtask : chk

  // One Avalon access, held until waitrequest is sampled low
  task automatic av(input logic w, input logic [4:0] a, input logic [7:0] wd, output logic [31:0] r);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= {24'h000000, wd};
    avs_write <= w;
    avs_read <= ~w;
    // Only the watchdog ends a wait that never gets its answer
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    r = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    // Waitrequest low stands for one cycle only
    @(posedge clk);
    chk("waitrequest", 1, avs_waitrequest);
  endtask : av

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [31:0] r;
    av(1'b1, a, d, r);
  endtask : wr

  task automatic rdchk(input string what, input logic [4:0] a, input logic [7:0] e);
    logic [31:0] r;
    av(1'b0, a, 8'h00, r);
    chk(what, {24'h000000, e}, r);
  endtask : rdchk

  // Hang guard, well beyond the expected run of under 10000 cycles
  initial begin
    repeat (40000) @(posedge clk);
    err_count++;
    conclude();
  end

  // Main sequence
  initial begin
    reset_n = 1'b0;
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h00000000;
    shutdown_in_n = 1'b1;
    addr_select_lo = 2'h0;
    addr_select_hi = 2'h0;
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    chk("idle data out", 1, split_data_out_oe);
    chk("plain idle data out", 0, sdo_oe2);
    // Scan order and dwell per channel
    for (int i = 1; i <= 6; i++) begin
      t0 = cyc;
      last = adc_chan;
      while (adc_chan === last && cyc - t0 < 200) @(posedge clk);
      chk("scan channel", (last + 1) % 3, adc_chan);
      if (i > 1) chk("scan dwell", SCAN, cyc - t0);
    end
    for (int c = 0; c < 3; c++) begin
      ev = res(c);
      rdchk("scan hi", 5'(8 * c), ev[11:4]);
      rdchk("scan lo", 5'(8 * c + 4), {ev[3:0], 4'h0});
    end
    // Reset value, unmapped place, locked data outside test mode
    rdchk("ctrl reset", 5'h18, 8'h0C);
    rdchk("unmapped read", 5'h19, 8'h00);
    wr(5'h1B, 8'hFF);
    rdchk("unmapped write", 5'h18, 8'h0C);
    wr(5'h00, 8'h5A);
    rdchk("data locked", 5'h00, 8'hA5);
    wr(5'h18, 8'h1C);
    wr(5'h08, 8'h5A);
    repeat (4 * SCAN) @(posedge clk);
    rdchk("frozen data", 5'h08, 8'h5A);
    host.rd(7'h60, 8'h02, b, nak);
    chk("serial read", 8'h5A, b);
    chk("serial read ack", 0, nak);
    host_plain.rd(7'h60, 8'h02, b, nak);
    chk("plain serial read", 8'h5A, b);
    chk("plain serial read ack", 0, nak);
    wr(5'h18, 8'h0C);
    // Snapshot on every channel code
    bias = 12'h100;
    for (int c = 0; c < 3; c++) begin
      snap = (c == 0) ? SNAP_S : SNAP_O;
      wr(5'h18, 8'h8C | 8'(c << 5));
      t0 = cyc;
      av(1'b0, 5'(8 * c + 4), 8'h00, rd);
      chk("busy set", 8'h08, rd & 32'h08);
      while (adc_run !== 1'b0 && cyc - t0 < 300) @(posedge clk);
      ok = (cyc - t0 >= snap - 3) && (cyc - t0 <= snap + 4);
      chk("snapshot length", 1, ok);
      repeat (2 * SCAN) @(posedge clk);
      chk("halted", 0, adc_run);
      ev = res(c);
      rdchk("snapshot hi", 5'(8 * c), ev[11:4]);
      rdchk("snapshot lo", 5'(8 * c + 4), {ev[3:0], 4'h0});
      wr(5'h18, 8'h8C | 8'(((c + 1) % 3) << 5));
      repeat (5) @(posedge clk);
      chk("no restart", 0, adc_run);
      wr(5'h18, 8'h0C);
      repeat (3) @(posedge clk);
      chk("scan resumes", 1, adc_run);
    end
    bias = 12'h000;
    // Shutdown pin
    shutdown_in_n <= 1'b0;
    repeat (10) @(posedge clk);
    chk("shutdown", 1, shutdown_active);
    shutdown_in_n <= 1'b1;
    repeat (10) @(posedge clk);
    chk("shutdown exit", 0, shutdown_active);
    // All nine select settings, a foreign address, then the mass address
    for (int k = 0; k < 9; k++) begin
      addr_select_hi <= 2'(k / 3);
      addr_select_lo <= 2'(k % 3);
      repeat (4) @(posedge clk);
      host.wr(7'h60 | 7'(k), 8'h06, 8'h1C, nak);
      chk("serial write ack", 0, nak);
      rdchk("serial write", 5'h18, 8'h1C);
      // The neighbour of setting 5 is the mass write address, so take another foreign one there
      host.wr((k == 5) ? 7'h67 : 7'h60 | 7'((k + 1) % 9), 8'h06, 8'h0C, nak);
      chk("foreign address", 1, nak);
      rdchk("foreign write", 5'h18, 8'h1C);
      wr(5'h18, 8'h0C);
    end
    host.wr(7'h66, 8'h06, 8'h1C, nak);
    rdchk("mass write", 5'h18, 8'h1C);
    conclude();
  end
endmodule : pms_adc_seq_test

//--- verif/pms_i2c_master.sv
// Serial bus master model for the split data pins of the monitor sequencer
`timescale 1ns/10ps
module pms_i2c_master #(
  parameter bit INVERT = 1'b1
) (
  // Pins toward the device
  output logic scl,
  output logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe
);
  // Master's own open-drain drive, 1 = released
  logic m_sda = 1'b1;
  // Device pin with its pull-up when not pulled low
  wire pin = sda_oe ? sda_out : 1'b1;
  // Logical device bit once the output polarity is undone
  wire dev_bit = INVERT ? ~pin : pin;
  // Device output echoed onto its input, wired with our own drive
  assign sda_in = m_sda & dev_bit;
  // Clock rests high outside frames
  initial scl = 1'b1;

  // One 200 ns bit slot: data set while low, sampled in the high phase
  task automatic slot(input logic b, output logic r);
    #25 m_sda = b;
    #75 scl = 1'b1;
    #50 r = sda_in;
    #50 scl = 1'b0;
  endtask : slot

  // Start or repeated start
  task automatic start();
    #25 m_sda = 1'b1;
    #75 scl = 1'b1;
    #100 m_sda = 1'b0;
    #100 scl = 1'b0;
  endtask : start

  // Stop, leaving the bus idle high
  task automatic stop();
    #25 m_sda = 1'b0;
    #75 scl = 1'b1;
    #100 m_sda = 1'b1;
    #100;
  endtask : stop

  // Byte MSB first, then the acknowledge slot
  task automatic xbyte(input logic [7:0] tx, input logic mack, output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--) slot(tx[i], rx[i]);
    slot(mack, ack);
  endtask : xbyte

  // Single-byte write through the register pointer
  task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d, output logic nak);
    logic [7:0] rx;
    logic k0, k1, k2;
    start();
    xbyte({a, 1'b0}, 1'b1, rx, k0);
    xbyte(p, 1'b1, rx, k1);
    xbyte(d, 1'b1, rx, k2);
    stop();
    nak = k0 | k1 | k2;
  endtask : wr

  // Single-byte read through a repeated start; last byte is not acknowledged
  task automatic rd(input logic [6:0] a, input logic [7:0] p, output logic [7:0] d, output logic nak);
    logic k0, k1, k2, k3;
    start();
    xbyte({a, 1'b0}, 1'b1, d, k0);
    xbyte(p, 1'b1, d, k1);
    start();
    xbyte({a, 1'b1}, 1'b1, d, k2);
    xbyte(8'hFF, 1'b1, d, k3);
    stop();
    nak = k0 | k1 | k2;
  endtask : rd
endmodule : pms_i2c_master
